// *** src/cpu_freq_program_select.sv ***
// What this block does
// - Bit 7 of the M register enables programmable frequency, reset to zero.
// - When enabled, CPU frequency comes from software N and M divider values.
// - When enabled, each write of the M field starts loading the new frequency.
// - Override clear: ratio comes from the latched strap frequency code.
// - Override set: ratio comes from the software frequency select field.
// - Reserved bits have no function; the 0x0f field resets to 3, the others to zero.
// - The 5-bit code decodes to fixed CPU/PCI pairs with one gear constant.
// - Disabled: frequency from straps or select bits per the override.
// - Enabled: the selected code still sets the CPU/PCI pair; the gear constant is fixed.
`timescale 1ns/1ns
`default_nettype none

module cpu_freq_program_select #(
  parameter logic [6:0] SLAVE_ADDR = 7'h5a
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [4:0] strap_frequency_code,
  output freq_sel_pkg::freq_sel_t freq_sel,
  output freq_sel_pkg::pll_div_t pll_div
);
  import freq_sel_pkg::*;

  typedef struct packed {
    logic scl;
    logic sda;
    bus_st_t st;
    bus_st_t nxt;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic nack;
    logic [7:0] idx;
    logic [7:0] n;
    logic [7:0] m;
    logic [5:0] ctl;
    logic [2:0] rsv_a;
    logic [4:0] strap;
    logic strap_done;
    logic sda_o;
    logic sda_e;
    freq_sel_t fs;
    pll_div_t pd;
  } state_t;

  state_t q, d;
  logic rise, fall, start, stop;
  logic [4:0] code;

  function automatic logic [7:0] read_reg(input state_t s, input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    // Unmapped indexes read as zero, so a block read across a gap still completes.
    if (a == REG_CTRL) begin
      r = {2'h0, s.ctl};
    end else if (a == REG_N) begin
      r = s.n;
    end else if (a == REG_M) begin
      r = s.m;
    end else if (a == REG_RSV_A) begin
      r = {5'h00, s.rsv_a};
    end
    return r;
  endfunction : read_reg

  // Loading the next read byte is shared by the address acknowledge and the host's acknowledge.
  function automatic state_t next_read(input state_t s);
    state_t t;
    t = s;
    t.sh = read_reg(s, s.idx);
    t.idx = s.idx + 8'h01;
    t.sda_e = ~t.sh[7];
    return t;
  endfunction : next_read

  // Override chooses the software code; otherwise the straps latched after reset stand.
  function automatic logic [4:0] pick_code(input logic [5:0] ctl, input logic [4:0] strap);
    return ctl[CTRL_OVR_BIT] ? ctl[4:0] : strap;
  endfunction : pick_code

  always_comb begin
    rise = ~q.scl & scl_in;
    fall = q.scl & ~scl_in;
    start = q.scl & scl_in & q.sda & ~sda_in;
    stop = q.scl & scl_in & ~q.sda & sda_in;
    d = q;
    d.scl = scl_in;
    d.sda = sda_in;
    d.pd.load = 1'b0;
    // Straps are caught once, on the first clock after reset is released.
    if (!q.strap_done) begin
      d.strap = strap_frequency_code;
      d.strap_done = 1'b1;
    end
    if (stop) begin
      d.st = ST_IDLE;
      d.sda_e = 1'b0;
    end else if (start) begin
      d.st = ST_ADDR;
      d.cnt = 4'h0;
      d.sda_e = 1'b0;
    end else begin
      case (q.st)
        ST_IDLE: begin
          d.sda_e = 1'b0;
        end
        ST_ADDR, ST_CMD, ST_WR: begin
          if (rise) begin
            d.sh = {q.sh[6:0], sda_in};
            d.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == BITS_PER_BYTE) begin
            d.cnt = 4'h0;
            d.st = ST_ACK;
            d.sda_e = 1'b1;
            if (q.st == ST_ADDR) begin
              // A foreign address gets no acknowledge and is ignored until the next start.
              if (q.sh[7:1] != SLAVE_ADDR) begin
                d.st = ST_IDLE;
                d.sda_e = 1'b0;
              end
              d.nxt = q.sh[0] ? ST_RD : ST_CMD;
            end else if (q.st == ST_CMD) begin
              d.idx = q.sh;
              d.nxt = ST_WR;
            end else begin
              d.nxt = ST_WR;
              d.idx = q.idx + 8'h01;
              if (q.idx == REG_CTRL) begin
                d.ctl = q.sh[5:0];
              end else if (q.idx == REG_N) begin
                d.n = q.sh;
              end else if (q.idx == REG_M) begin
                d.m = q.sh;
                d.pd.load = q.sh[M_EN_BIT];
              end else if (q.idx == REG_RSV_A) begin
                d.rsv_a = q.sh[2:0];
              end
            end
          end
        end
        ST_ACK: begin
          // Sda only moves a clock after scl falls, so it is settled long before the host samples it.
          if (fall) begin
            d.sda_e = 1'b0;
            d.st = q.nxt;
            if (q.nxt == ST_RD) begin
              d = next_read(d);
            end
          end
        end
        ST_RD: begin
          if (fall) begin
            d.cnt = q.cnt + 4'h1;
            // The eighth fall hands sda back for the host's acknowledge.
            if (d.cnt == BITS_PER_BYTE) begin
              d.sda_e = 1'b0;
              d.st = ST_MACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_e = ~q.sh[6];
            end
          end
        end
        ST_MACK: begin
          if (rise) begin
            d.nack = sda_in;
          end else if (fall) begin
            d.cnt = 4'h0;
            if (q.nack) begin
              d.st = ST_IDLE;
            end else begin
              d.st = ST_RD;
              d = next_read(d);
            end
          end
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
    end
    code = pick_code(q.ctl, q.strap);
    d.fs.code = code;
    d.fs.cpu_freq = CPU_TBL[code];
    d.fs.pci_freq = PCI_TBL[code];
    d.fs.gear = GEAR_CONST_PPM;
    d.pd.use_prog = q.m[M_EN_BIT];
    // The PLL dividers move together only on an M write, so a lone N write never glitches the clock.
    if (q.pd.load) begin
      d.pd.n = q.n;
      d.pd.m = q.m[6:0];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.scl <= 1'b1;
      q.sda <= 1'b1;
      q.st <= ST_IDLE;
      q.nxt <= ST_IDLE;
      q.rsv_a <= RSV_A_RESET;
    end else begin
      q <= d;
    end
  end

  assign sda_out = q.sda_o;
  assign sda_oe = q.sda_e;
  assign freq_sel = q.fs;
  assign pll_div = q.pd;

endmodule : cpu_freq_program_select

`default_nettype wire

// *** src/freq_sel_pkg.sv ***
package freq_sel_pkg;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_N = 8'h0d;
  localparam logic [7:0] REG_M = 8'h0e;
  localparam logic [7:0] REG_RSV_A = 8'h0f;
  localparam logic [7:0] REG_RSV_B = 8'h10;
  localparam logic [7:0] REG_RSV_C = 8'h11;

  localparam int M_EN_BIT = 7;
  localparam int CTRL_OVR_BIT = 5;
  localparam logic [2:0] RSV_A_RESET = 3'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [31:0] GEAR_CONST_PPM = 32'h02dc_6ee5;

  // Frequencies are held in tenths of a MHz.
  localparam logic [15:0] CPU_TBL [32] = '{
    16'd2000, 16'd1900, 16'd1800, 16'd1700, 16'd1660, 16'd1600, 16'd1500, 16'd1450,
    16'd1400, 16'd1360, 16'd1300, 16'd1240, 16'd672, 16'd1008, 16'd1180, 16'd1344,
    16'd670, 16'd1005, 16'd1150, 16'd1340, 16'd668, 16'd1002, 16'd1100, 16'd1336,
    16'd1050, 16'd900, 16'd850, 16'd780, 16'd666, 16'd1000, 16'd750, 16'd1333};
  localparam logic [15:0] PCI_TBL [32] = '{
    16'd333, 16'd380, 16'd360, 16'd340, 16'd332, 16'd320, 16'd375, 16'd363,
    16'd350, 16'd340, 16'd325, 16'd310, 16'd336, 16'd336, 16'd393, 16'd336,
    16'd335, 16'd335, 16'd383, 16'd335, 16'd334, 16'd334, 16'd367, 16'd334,
    16'd350, 16'd300, 16'd283, 16'd390, 16'd333, 16'd333, 16'd375, 16'd333};

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_WR, ST_ACK, ST_RD, ST_MACK} bus_st_t;

  typedef struct packed {
    logic [15:0] cpu_freq;
    logic [15:0] pci_freq;
    logic [31:0] gear;
    logic [4:0] code;
  } freq_sel_t;

  typedef struct packed {
    logic use_prog;
    logic load;
    logic [7:0] n;
    logic [6:0] m;
  } pll_div_t;

endpackage : freq_sel_pkg

// *** verif/freq_sel_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module freq_sel_monitor (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [4:0] strap_frequency_code,
  input wire freq_sel_pkg::freq_sel_t freq_sel,
  input wire freq_sel_pkg::pll_div_t pll_div
);
  import freq_sel_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sda_out high");
  property p_oe; $changed(sda_oe) |-> !scl_in; endproperty
  a_oe: assert property (p_oe) else $error("sda_oe moved with scl high");
  property p_ld; $rose(pll_div.load) |=> !pll_div.load; endproperty
  a_ld: assert property (p_ld) else $error("load not one cycle");
  property p_en; pll_div.load |=> pll_div.use_prog; endproperty
  a_en: assert property (p_en) else $error("load while disabled");
  property p_m; !$past(pll_div.load) |-> $stable(pll_div.m); endproperty
  a_m: assert property (p_m) else $error("m moved without load");
  // Outputs settle from the second edge after reset, so the edge before must be out of reset.
  property p_g; !$past(sys_rst) |-> freq_sel.gear == 32'h02dc6ee5; endproperty
  a_g: assert property (p_g) else $error("gear wrong");
  property p_c0; !$past(sys_rst) && freq_sel.code == 5'h00 |-> freq_sel.cpu_freq == 16'h07d0; endproperty
  a_c0: assert property (p_c0) else $error("code 0 cpu wrong");
  property p_c1; freq_sel.code == 5'h1f |-> freq_sel.pci_freq == 16'h014d; endproperty
  a_c1: assert property (p_c1) else $error("code 1f pci wrong");
  c_ld: cover property (pll_div.load);
  c_oe: cover property ($rose(sda_oe));
  c_c0: cover property (freq_sel.code == 5'h00);
endmodule : freq_sel_monitor
bind cpu_freq_program_select freq_sel_monitor MON (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .strap_frequency_code(strap_frequency_code), .freq_sel(freq_sel), .pll_div(pll_div));
`default_nettype wire

// *** verif/smb_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module smb_host (
  input wire logic ref_clk,
  input wire logic sda_bus,
  output logic scl = 1'b1,
  output logic sda_drv = 1'b1
);
  // Data only moves while the clock is low, so no false start or stop.
  task automatic step(input logic c, input logic d);
    @(posedge ref_clk);
    #1;
    scl = c;
    sda_drv = d;
    repeat (4) @(posedge ref_clk);
  endtask : step
  task automatic xb(input logic [7:0] w, input logic m, output logic [7:0] r, output logic a);
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, sda_drv);
      step(1'b0, (i == 0) ? m : w[i-1]);
      step(1'b1, sda_drv);
      if (i == 0) a = sda_bus;
      else r[i-1] = sda_bus;
    end
  endtask : xb
  task automatic start();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask : start
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop
endmodule : smb_host
`default_nettype wire

// *** verif/test_cpu_freq_program_select.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module test_cpu_freq_program_select;
  import freq_sel_pkg::*;
  localparam logic [6:0] ADR = 7'h2c;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] strap = 5'h1f;
  logic scl, sda_drv, sda_oe, sda_out;
  logic [7:0] r;
  logic a;
  wire logic sda_bus = sda_drv & (sda_oe ? sda_out : 1'b1);
  freq_sel_t fs;
  pll_div_t pd;
  int err_count = 0;
  int checks = 0;
  logic [4:0] cx [3] = '{5'h00, 5'h0c, 5'h1b};
  logic [15:0] ce [3] = '{16'h07d0, 16'h02a0, 16'h030c};
  logic [15:0] pe [3] = '{16'h014d, 16'h0150, 16'h0186};
  cpu_freq_program_select #(.SLAVE_ADDR(ADR)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe), .strap_frequency_code(strap), .freq_sel(fs),
    .pll_div(pd));
  smb_host HOST (.ref_clk(ref_clk), .sda_bus(sda_bus), .scl(scl), .sda_drv(sda_drv));
  task automatic wr(input logic [7:0] i, input logic [15:0] d, input logic two);
    logic [7:0] q;
    logic b, c, e, f;
    f = 1'b0;
    HOST.start();
    HOST.xb({ADR, 1'b0}, 1'b1, q, b);
    HOST.xb(i, 1'b1, q, c);
    HOST.xb(d[15:8], 1'b1, q, e);
    if (two) HOST.xb(d[7:0], 1'b1, q, f);
    HOST.stop();
    `CHK("ack", 1'b0, b | c | e | f)
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] x);
    logic [7:0] q;
    logic b;
    HOST.start();
    HOST.xb({ADR, 1'b0}, 1'b1, q, b);
    HOST.xb(i, 1'b1, q, b);
    HOST.start();
    HOST.xb({ADR, 1'b1}, 1'b1, q, b);
    HOST.xb(8'hff, 1'b1, q, b);
    HOST.stop();
    `CHK("reg", x, q)
  endtask : rd
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #1000000;
    err_count++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("cpu", 16'h0535, fs.cpu_freq)
    `CHK("gear", 32'h02dc6ee5, fs.gear)
    rd(8'h0e, 8'h00);
    rd(8'h0f, 8'h03);
    rd(8'h11, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      wr(8'h00, {3'h1, cx[k], 8'h00}, 1'b0);
      `CHK("cpu", ce[k], fs.cpu_freq)
      `CHK("pci", pe[k], fs.pci_freq)
    end
    $display("test select done");
    // Divider pair picked inside the supported frequency span.
    wr(8'h0d, 16'h2a85, 1'b1);
    `CHK("n", 8'h2a, pd.n)
    `CHK("m", 7'h05, pd.m)
    `CHK("en", 1'b1, pd.use_prog)
    `CHK("code", 5'h1b, fs.code)
    rd(8'h0e, 8'h85);
    $display("test program done");
    wr(8'h0f, 16'hfbff, 1'b1);
    rd(8'h0f, 8'h03);
    rd(8'h10, 8'h00);
    HOST.start();
    HOST.xb({~ADR, 1'b0}, 1'b1, r, a);
    HOST.stop();
    `CHK("nak", 1'b1, a)
    $display("test reserved done");
    // A second reset must drop the enable and the divider register back to idle.
    @(posedge ref_clk);
    #1 sys_rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("en", 1'b0, pd.use_prog)
    `CHK("code", 5'h1f, fs.code)
    rd(8'h0e, 8'h00);
    $display("test rerun done");
    finish_test();
  end
endmodule : test_cpu_freq_program_select
`default_nettype wire
